//--- shared/sei_pkg.sv
// Package with constants and types of the standard encoder evaluation block.
package sei_pkg;
    // Width of one analog-to-digital conversion result.
    localparam int ADC_WIDTH = 12;
    // Width of the actual position value.
    localparam int POS_WIDTH = 32;
    // Width of the absolute position word taken from the serial link.
    localparam int ABS_WIDTH = 32;
    // Synchroniser depth for inputs from outside the clock domain.
    localparam int SYNC_DEPTH = 3;
    // Serial link clock half period, in ns, and in system clock cycles (40 MHz).
    localparam int LINK_HALF_NS     = 1000;
    localparam int CLK_PERIOD_NS    = 25;
    localparam int LINK_HALF_CYCLES = LINK_HALF_NS / CLK_PERIOD_NS;
    // Idle time before a new serial request, in ns and cycles (rounded up).
    localparam int LINK_IDLE_NS     = 20000;
    localparam int LINK_IDLE_CYCLES = (LINK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Quadrant zero in the two-bit phase code {a, b}.
    localparam logic [1:0] QUAD_ZERO = 2'h3;

    // Encoder classes served by the input.
    typedef enum logic [2:0] {
        SEI_SINE_REF,
        SEI_TTL_REF,
        SEI_SINE_BIDIR_21,
        SEI_SINE_BIDIR_22,
        SEI_SINE_ALT_LINK,
        SEI_SINE_SSI
    } sei_class_t;
endpackage : sei_pkg

//--- design/sei_serial_link.sv
// Serial absolute position reader: drives the link clock and shifts in position data.
`timescale 1ns/10ps
module sei_serial_link
    import sei_pkg::*;
#(
    parameter int WIDTH = ABS_WIDTH
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_b_i,
    // Control
    input  wire logic             start_i,
    // Synchronised serial data line
    input  wire logic             data_i,
    // Link clock drive
    output logic                  link_clk_o,
    // Result
    output logic [WIDTH-1:0]      value_o,
    output logic                  done_o
);
    // The shift register needs two bits at least and the bit counter holds 64.
    if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
        $error("sei_serial_link: WIDTH out of range");
    end

    typedef enum logic [1:0] {LNK_IDLE, LNK_SHIFT, LNK_GAP} sei_lnk_t;

    sei_lnk_t         state;
    logic [15:0]      tick;
    logic [6:0]       bits;
    logic [WIDTH-1:0] shreg;

    // Link clock rests high; data is sampled on each rising edge of the link clock.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state      <= LNK_IDLE;
            tick       <= 16'h0000;
            bits       <= 7'h00;
            shreg      <= '0;
            link_clk_o <= 1'b1;
            value_o    <= '0;
            done_o     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            unique case (state)
                LNK_IDLE: begin
                    if (start_i) begin
                        state      <= LNK_SHIFT;
                        tick       <= 16'h0000;
                        bits       <= 7'h00;
                        link_clk_o <= 1'b0;
                    end
                end
                LNK_SHIFT: begin
                    if (tick == 16'(LINK_HALF_CYCLES - 1)) begin
                        tick       <= 16'h0000;
                        link_clk_o <= ~link_clk_o;
                        if (!link_clk_o) begin
                            shreg <= {shreg[WIDTH-2:0], data_i};
                            bits  <= bits + 7'h01;
                            if (bits == 7'(WIDTH - 1)) begin
                                state   <= LNK_GAP;
                                value_o <= {shreg[WIDTH-2:0], data_i};
                                done_o  <= 1'b1;
                            end
                        end
                    end else begin
                        tick <= tick + 16'h0001;
                    end
                end
                LNK_GAP: begin
                    link_clk_o <= 1'b1;
                    if (tick == 16'(LINK_IDLE_CYCLES - 1)) begin
                        state <= LNK_IDLE;
                        tick  <= 16'h0000;
                    end else begin
                        tick <= tick + 16'h0001;
                    end
                end
            endcase
        end
    end
endmodule : sei_serial_link

//--- design/sei_encoder_eval.sv
// Top of the standard encoder evaluation: tracks to actual position value.
//
// Functional notes
// - Serves sine-ref, TTL-ref, sine plus serial classes.
// - Analog tracks arrive as 12-bit conversion results.
// - A leading B counts position upward.
// - Negation setting reverses the counting direction.
// - Reference mark accepted only in quadrant zero.
// - Absolute value only with serial link classes.
`timescale 1ns/10ps
module sei_encoder_eval
    import sei_pkg::*;
#(
    parameter int ADC_W = ADC_WIDTH,
    parameter int POS_W = POS_WIDTH,
    parameter int ABS_W = ABS_WIDTH
) (
    // Clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rst_b_i,
    // Configuration
    input  wire logic [2:0]              encoder_class_i,
    input  wire logic                    negate_i,
    input  wire logic                    abs_request_i,
    // Digitised sine tracks, two's complement
    input  wire logic signed [ADC_W-1:0] sine_a_i,
    input  wire logic signed [ADC_W-1:0] sine_b_i,
    input  wire logic signed [ADC_W-1:0] sine_r_i,
    input  wire logic                    sine_valid_i,
    // Square-wave tracks
    input  wire logic                    ttl_a_i,
    input  wire logic                    ttl_b_i,
    input  wire logic                    ttl_r_i,
    // Serial link
    input  wire logic                    encoder_serial_data_pos_i,
    output logic                         encoder_serial_clock_pos_o,
    output logic                         encoder_serial_clock_neg_o,
    // Results
    output logic signed [POS_W-1:0]      position_o,
    output logic [ABS_W-1:0]             abs_position_o,
    output logic                         abs_valid_o,
    output logic                         ref_mark_o,
    output logic                         count_error_o
);
    // Widths that the datapath cannot serve are refused at elaboration.
    if (ADC_W != ADC_WIDTH) begin : g_bad_adc
        $error("sei_encoder_eval: ADC_W must match converter width");
    end
    if (POS_W < 2 || POS_W > 64) begin : g_bad_pos
        $error("sei_encoder_eval: POS_W out of range");
    end
    if (ABS_W < 2 || ABS_W > 64) begin : g_bad_abs
        $error("sei_encoder_eval: ABS_W out of range");
    end
    if (SYNC_DEPTH < 3) begin : g_bad_sync
        $error("sei_encoder_eval: SYNC_DEPTH below three");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers for pin-level signals, one lane per pin.
    localparam int                N_PINS  = 4;
    // Lane order is TTL A, TTL B, TTL R, serial data; the data lane resets high.
    localparam logic [N_PINS-1:0] PIN_RST = 4'h8;

    logic [N_PINS-1:0] pin_raw;
    logic              pin_lvl [N_PINS];
    logic              ttl_a;
    logic              ttl_b;
    logic              ttl_r;
    logic              ser_d;

    assign pin_raw = {encoder_serial_data_pos_i, ttl_r_i, ttl_b_i, ttl_a_i};
    assign ttl_a   = pin_lvl[0];
    assign ttl_b   = pin_lvl[1];
    assign ttl_r   = pin_lvl[2];
    assign ser_d   = pin_lvl[3];

    for (genvar g = 0; g < N_PINS; g++) begin : g_pin
        logic [SYNC_DEPTH-1:0] stage;

        always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                stage <= '0;
            end else begin
                stage <= {stage[SYNC_DEPTH-2:0], pin_raw[g]};
            end
        end

        // A level is accepted once the last two stages agree.
        always_ff @(posedge mclk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                pin_lvl[g] <= PIN_RST[g];
            end else if (stage[SYNC_DEPTH-2] == stage[SYNC_DEPTH-1]) begin
                pin_lvl[g] <= stage[SYNC_DEPTH-1];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Track selection by encoder class.
    // Serial link classes take their incremental tracks from the sine inputs.
    logic is_ttl;
    logic has_abs;
    logic cur_a;
    logic cur_b;
    logic cur_r;

    always_comb begin
        is_ttl  = (encoder_class_i == 3'(SEI_TTL_REF));
        has_abs = (encoder_class_i == 3'(SEI_SINE_BIDIR_21))
               || (encoder_class_i == 3'(SEI_SINE_BIDIR_22))
               || (encoder_class_i == 3'(SEI_SINE_ALT_LINK))
               || (encoder_class_i == 3'(SEI_SINE_SSI));
        // A positive conversion result means a positive track.
        cur_a = is_ttl ? ttl_a : ~sine_a_i[ADC_W-1];
        cur_b = is_ttl ? ttl_b : ~sine_b_i[ADC_W-1];
        cur_r = is_ttl ? ttl_r : ~sine_r_i[ADC_W-1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Quadrature decoding.
    logic       samp_en;
    logic [1:0] prev_ph;
    logic       prev_r;
    logic       primed;
    logic [1:0] cur_ph;
    logic       step_up;
    logic       step_dn;
    logic       step_bad;

    assign samp_en = is_ttl | sine_valid_i;
    // Gray phase sequence 00 -> 10 -> 11 -> 01 when A leads B.
    assign cur_ph  = {cur_a, cur_b};

    always_comb begin
        step_up  = 1'b0;
        step_dn  = 1'b0;
        step_bad = 1'b0;
        if (samp_en && primed && cur_ph != prev_ph) begin
            unique case ({prev_ph, cur_ph})
                4'h2, 4'hB, 4'hD, 4'h4: step_up = 1'b1;
                4'h1, 4'h7, 4'hE, 4'h8: step_dn = 1'b1;
                default:                step_bad = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prev_ph <= 2'h0;
            prev_r  <= 1'b0;
            primed  <= 1'b0;
        end else if (samp_en) begin
            prev_ph <= cur_ph;
            prev_r  <= cur_r;
            primed  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Position counter, reference mark and error flag.
    // Negation swaps only the step direction; the decoding itself is unchanged.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            position_o <= '0;
        end else if (step_up) begin
            position_o <= negate_i ? position_o - POS_W'(1) : position_o + POS_W'(1);
        end else if (step_dn) begin
            position_o <= negate_i ? position_o + POS_W'(1) : position_o - POS_W'(1);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ref_mark_o <= 1'b0;
        end else begin
            ref_mark_o <= samp_en && primed && cur_r && !prev_r
                       && cur_ph == QUAD_ZERO;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count_error_o <= 1'b0;
        end else begin
            count_error_o <= step_bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial absolute link.
    logic             lnk_clk;
    logic [ABS_W-1:0] lnk_value;
    logic             lnk_done;

    sei_serial_link #(
        .WIDTH (ABS_W)
    ) u_link (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .start_i    (abs_request_i & has_abs),
        .data_i     (ser_d),
        .link_clk_o (lnk_clk),
        .value_o    (lnk_value),
        .done_o     (lnk_done)
    );

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            encoder_serial_clock_pos_o <= 1'b1;
            encoder_serial_clock_neg_o <= 1'b0;
            abs_position_o             <= '0;
            abs_valid_o                <= 1'b0;
        end else begin
            encoder_serial_clock_pos_o <= lnk_clk;
            encoder_serial_clock_neg_o <= ~lnk_clk;
            abs_valid_o                <= lnk_done & has_abs;
            if (lnk_done && has_abs) abs_position_o <= lnk_value;
        end
    end
endmodule : sei_encoder_eval

//--- tb/sei_encoder_eval_sva.sv
// Checker of the standard encoder evaluation outputs.
`timescale 1ns/10ps
module sei_encoder_eval_sva
    import sei_pkg::*;
(
    // Clock, reset and stimulus
    input wire logic                        mclk_i,
    input wire logic                        rst_b_i,
    input wire logic [2:0]                  encoder_class_i,
    input wire logic signed [ADC_WIDTH-1:0] sine_a_i,
    input wire logic signed [ADC_WIDTH-1:0] sine_b_i,
    input wire logic                        sine_valid_i,
    // Results
    input wire logic                        encoder_serial_clock_pos_o,
    input wire logic                        encoder_serial_clock_neg_o,
    input wire logic signed [POS_WIDTH-1:0] position_o,
    input wire logic [ABS_WIDTH-1:0]        abs_position_o,
    input wire logic                        abs_valid_o,
    input wire logic                        ref_mark_o,
    input wire logic                        count_error_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    ////////////////////////////////////////
    property p_step;
        $changed(position_o) |-> (position_o - $past(position_o)) inside {1, -1};
    endproperty
    a_step: assert property (p_step) else $error("position jumped");
    property p_err_hold; count_error_o |-> $stable(position_o); endproperty
    a_err_hold: assert property (p_err_hold) else $error("step on error");
    property p_ref_pulse; ref_mark_o |=> !ref_mark_o; endproperty
    a_ref_pulse: assert property (p_ref_pulse) else $error("long mark pulse");
    property p_ref_quad;
        ref_mark_o && encoder_class_i == 3'h0 |->
            $past(sine_valid_i && !sine_a_i[ADC_WIDTH-1] && !sine_b_i[ADC_WIDTH-1]);
    endproperty
    a_ref_quad: assert property (p_ref_quad) else $error("mark off quadrant");
    property p_abs_pulse; abs_valid_o |=> !abs_valid_o; endproperty
    a_abs_pulse: assert property (p_abs_pulse) else $error("long abs pulse");
    property p_abs_class; abs_valid_o |-> encoder_class_i inside {[3'h2:3'h5]}; endproperty
    a_abs_class: assert property (p_abs_class) else $error("abs in wrong class");
    property p_abs_hold; $changed(abs_position_o) |-> abs_valid_o; endproperty
    a_abs_hold: assert property (p_abs_hold) else $error("abs word moved");
    property p_clk_pair; encoder_serial_clock_neg_o == !encoder_serial_clock_pos_o; endproperty
    a_clk_pair: assert property (p_clk_pair) else $error("clock pair split");
    property p_clk_half;
        $changed(encoder_serial_clock_pos_o) |=> $stable(encoder_serial_clock_pos_o)[*8];
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("link half short");
    c_abs: cover property (abs_valid_o);
    c_ref: cover property (ref_mark_o);
    c_err: cover property (count_error_o);
endmodule : sei_encoder_eval_sva
bind sei_encoder_eval sei_encoder_eval_sva u_sva (.*);

//--- tb/sei_encoder_model.sv
// Encoder model: square-wave tracks and serial position word.
`timescale 1ns/10ps
module sei_encoder_model (
    // Commands from the bench
    input  wire logic [1:0]  phase_i,
    input  wire logic        ref_i,
    input  wire logic [31:0] word_i,
    // Link and tracks
    input  wire logic        link_clk_i,
    output logic             data_o,
    output logic             ttl_a_o,
    output logic             ttl_b_o,
    output logic             ttl_r_o
);
    int  idx = -1;
    time t_last = 0;
    assign {ttl_a_o, ttl_b_o} = phase_i;
    assign ttl_r_o = ref_i;
    initial data_o = 1'b0;
    // A long high link clock marks a new frame; bits leave MSB first.
    always @(negedge link_clk_i) begin
        idx = ($time - t_last > 3000) ? 31 : idx - 1;
        t_last = $time;
        data_o = (idx >= 0) ? word_i[idx] : ~data_o;
    end
    // After the last bit the line is released and shows the inverse level.
    always @(posedge link_clk_i) if (idx == 0) data_o <= #500 ~data_o;
endmodule : sei_encoder_model

//--- tb/sei_encoder_eval_tb.sv
// Self-checking bench of the standard encoder evaluation.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module sei_encoder_eval_tb;
    logic               mclk_i = 1'b0;
    logic               rst_b_i = 1'b0;
    logic [2:0]         encoder_class_i = 3'h0;
    logic               negate_i = 1'b0;
    logic               abs_request_i = 1'b0;
    logic signed [11:0] sine_a_i = 12'h800;
    logic signed [11:0] sine_b_i = 12'h800;
    logic signed [11:0] sine_r_i = 12'h800;
    logic               sine_valid_i = 1'b0;
    logic               ttl_a_i, ttl_b_i, ttl_r_i, encoder_serial_data_pos_i;
    logic               encoder_serial_clock_pos_o, encoder_serial_clock_neg_o;
    logic signed [31:0] position_o;
    logic [31:0]        abs_position_o, word = 32'h0;
    logic               abs_valid_o, ref_mark_o, count_error_o, ref_lvl = 1'b0;
    logic [1:0]         ph = 2'h0;
    logic [1:0]         tbl [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int n_mismatch = 0, check_count = 0, exp_pos = 0, exp_ref = 0, exp_err = 0, exp_abs = 0;
    int n_ref = 0, n_err = 0, n_abs = 0, idx = 0;
    sei_encoder_eval DUT (.*);
    sei_encoder_model u_enc (.phase_i(ph), .ref_i(ref_lvl), .word_i(word),
        .link_clk_i(encoder_serial_clock_pos_o), .data_o(encoder_serial_data_pos_i),
        .ttl_a_o(ttl_a_i), .ttl_b_o(ttl_b_i), .ttl_r_o(ttl_r_i));
    initial forever #12.5 mclk_i = ~mclk_i;
    // Pulses are counted at the falling edge, where the outputs have settled.
    always @(negedge mclk_i) begin
        n_ref += ref_mark_o;
        n_err += count_error_o;
        n_abs += abs_valid_o;
    end
    ////////////////////////////////////////
    function automatic logic signed [11:0] lvl(input logic up);
        int m;
        m = int'($urandom_range(2047, 1));
        return up ? 12'(m) : 12'(-m);
    endfunction : lvl
    task automatic drive(input logic [1:0] code, input logic r);
        @(posedge mclk_i);
        ph <= code;
        ref_lvl <= r;
        sine_a_i <= lvl(code[1]);
        sine_b_i <= lvl(code[0]);
        sine_r_i <= lvl(r);
        sine_valid_i <= 1'b1;
        @(posedge mclk_i);
        sine_valid_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
    endtask : drive
    task automatic step(input int d);
        idx = (idx + d + 4) % 4;
        drive(tbl[idx], 1'b0);
        if (d == 2) exp_err++;
        else exp_pos += negate_i ? -d : d;
        `CHK("position", 32'(exp_pos), position_o)
        `CHK("errors", exp_err, n_err)
    endtask : step
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        void'($urandom(17358));
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        drive(2'h0, 1'b0);
        for (int c = 0; c < 2; c++) begin
            encoder_class_i <= 3'(c);
            for (int n = 0; n < 2; n++) begin
                negate_i <= n[0];
                repeat (12) step($urandom_range(1) ? 1 : -1);
                step(2);
            end
            while (idx != 2) step(1);
            drive(2'h3, 1'b1);
            exp_ref++;
            drive(2'h3, 1'b0);
            step(1);
            drive(2'h1, 1'b1);
            drive(2'h1, 1'b0);
            `CHK("ref marks", exp_ref, n_ref)
            $display("test quadrature class %0d done", c);
        end
        for (int c = 0; c < 6; c++) begin
            encoder_class_i <= 3'(c);
            word <= $urandom;
            @(posedge mclk_i);
            abs_request_i <= 1'b1;
            @(posedge mclk_i);
            abs_request_i <= 1'b0;
            for (int k = 0; k < 3000 && n_abs == exp_abs; k++) @(posedge mclk_i);
            if (c >= 2) exp_abs++;
            `CHK("abs reads", exp_abs, n_abs)
            `CHK("abs word", c >= 2 ? word : 32'h0, abs_position_o)
            repeat (900) @(posedge mclk_i);
            step(1);
            $display("test serial class %0d done", c);
        end
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        n_mismatch++;
        complete_run();
    end
endmodule : sei_encoder_eval_tb
